// *** device_config_word_decode.sv ***
// Configuration word latch, decode and APB control registers.
`timescale 1ns/100ps
module device_config_word_decode import cfg_decode_pkg::*; #(
  parameter logic [27:0] DEVICE_ID = 28'h0000001, // Arbitrary value.
  parameter logic [3:0] REVISION = 4'h1, // Arbitrary value.
  parameter bit SMALL_PACKAGE = 1'b0
) (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Non-volatile configuration words.
  input wire logic [31:0] i_nv_word0,
  input wire logic [31:0] i_nv_word1,
  // Flash access checks.
  input wire logic i_ext_prog_req,
  input wire logic i_self_write_req,
  input wire logic [19:0] i_self_write_addr,
  input wire logic i_self_write_boot,
  output logic o_ext_prog_allow,
  output logic o_self_write_allow,
  // APB slave.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [15:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Decoded settings.
  output logic o_code_protect,
  output logic o_boot_flash_write_guard,
  output logic [9:0] o_program_flash_write_guard,
  output logic [19:0] o_guard_limit,
  output logic [1:0] o_debug_channel_select,
  output logic o_debug_enable,
  output logic o_scan_port_enable,
  output logic o_scan_data_out_enable,
  output logic o_trace_output_enable,
  output logic o_pin_select_lock,
  output logic o_module_disable_lock,
  output logic [3:0] o_watchdog_window_size,
  output logic o_watchdog_force_on,
  output logic o_watchdog_window_off,
  output logic [4:0] o_watchdog_postscale,
  output logic [31:0] o_unlock_key
);
  typedef enum logic [1:0] {ST_LOAD = 2'h1, ST_RUN = 2'h2} load_state_t;
  load_state_t state_q;
  logic [31:0] word0_q;
  logic [31:0] word1_q;
  logic [31:0] ctl_q;
  logic [31:0] key_q;
  logic [31:0] ctl_mask;
  logic wr_en;
  logic rd_en;
  logic hit;
  logic protect_on;
  logic [9:0] page_cnt;

  // Address decode shared by read and write paths.
  function automatic logic mapped(input logic [15:0] a);
    mapped = (a == OFS_CONFIG_CONTROL) || (a == OFS_PART_IDENTITY) ||
             (a == OFS_UNLOCK_KEY) || (a == OFS_CFG_WORD0) || (a == OFS_CFG_WORD1);
  endfunction

  // Trace enable is dropped from the writable set on the small package; kept as a
  // constant so the asynchronous reset branch loads nothing but constants.
  localparam logic [31:0] CTL_MASK_EFF = SMALL_PACKAGE ?
    (CTL_IMPL_MASK & ~(32'h00000001 << CTL_TRACE_EN)) : CTL_IMPL_MASK;
  assign ctl_mask = CTL_MASK_EFF;
  assign hit = mapped(i_paddr);
  assign wr_en = i_psel && i_penable && i_pwrite && hit && (state_q == ST_RUN);
  assign rd_en = i_psel && i_penable && !i_pwrite && hit;
  // Zero wait states once loaded; held off during the single load cycle.
  assign o_pready = (state_q == ST_RUN);
  assign o_pslverr = i_psel && i_penable && !hit;

  // Capture the words once after reset release, then hold them; a strap must not
  // enter the async reset path, so the load is a clocked step.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_LOAD;
      word0_q <= 32'h00000000;
      word1_q <= 32'h00000000;
    end else begin
      case (state_q)
        ST_LOAD: begin
          word0_q <= i_nv_word0; // [RULE_18]
          word1_q <= i_nv_word1; // [RULE_18]
          state_q <= ST_RUN;
        end
        ST_RUN: state_q <= ST_RUN;
        default: state_q <= ST_LOAD;
      endcase
    end
  end

  // Control register: scan enable seeded from word 0 at load, then software owned.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ctl_q <= CTL_RESET & CTL_MASK_EFF;
    end else if (state_q == ST_LOAD) begin
      ctl_q[CTL_SCAN_EN] <= i_nv_word0[W0_SCAN_EN]; // [RULE_06]
    end else if (wr_en && i_paddr == OFS_CONFIG_CONTROL) begin
      ctl_q <= i_pwdata & ctl_mask; // [RULE_16] [RULE_17]
    end
  end

  // Unlock key register.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      key_q <= KEY_RESET;
    end else if (wr_en && i_paddr == OFS_UNLOCK_KEY) begin
      key_q <= i_pwdata;
    end
  end

  // Read data is registered so the data path comes from flip-flops.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_prdata <= 32'h00000000;
    end else if (i_psel && !i_penable) begin
      case (i_paddr)
        OFS_CONFIG_CONTROL: o_prdata <= ctl_q & ctl_mask; // [RULE_16]
        OFS_PART_IDENTITY: o_prdata <= {REVISION, DEVICE_ID}; // [RULE_15]
        OFS_UNLOCK_KEY: o_prdata <= key_q;
        OFS_CFG_WORD0: o_prdata <= word0_q;
        OFS_CFG_WORD1: o_prdata <= word1_q;
        default: o_prdata <= 32'h00000000;
      endcase
    end
  end

  // Protection decode.
  assign protect_on = !word0_q[W0_CODE_PROTECT]; // [RULE_01]
  assign o_code_protect = protect_on;
  assign o_boot_flash_write_guard = !word0_q[W0_BOOT_GUARD]; // [RULE_02]
  assign o_program_flash_write_guard = word0_q[W0_PAGE_GUARD_LO +: 10];
  assign page_cnt = ~word0_q[W0_PAGE_GUARD_LO +: 10]; // [RULE_03]
  // Page guard only counts while the boot guard is active.
  assign o_guard_limit = o_boot_flash_write_guard ?
                         {page_cnt, 10'h000} : 20'h00000; // [RULE_03] [RULE_04]
  assign o_ext_prog_allow = i_ext_prog_req && !protect_on; // [RULE_01]
  assign o_self_write_allow = i_self_write_req &&
    (i_self_write_boot ? !o_boot_flash_write_guard : // [RULE_02]
     (i_self_write_addr >= o_guard_limit)); // [RULE_04]

  // Debug: field forced to 11 while protected; upper bit low enables debugger.
  always_comb begin
    logic [1:0] dbg;
    dbg = protect_on ? 2'h3 : word0_q[W0_DEBUG_LO +: 2]; // [RULE_07]
    o_debug_enable = (state_q == ST_RUN) && !dbg[1]; // [RULE_07]
  end
  assign o_debug_channel_select = word0_q[W0_CHAN_LO +: 2]; // [RULE_05]
  assign o_scan_port_enable = ctl_q[CTL_SCAN_EN]; // [RULE_06]
  assign o_scan_data_out_enable = ctl_q[CTL_SCAN_DO_EN];
  assign o_trace_output_enable = ctl_q[CTL_TRACE_EN] && !SMALL_PACKAGE; // [RULE_17]
  assign o_pin_select_lock = ctl_q[CTL_PIN_LOCK];
  assign o_module_disable_lock = ctl_q[CTL_MODULE_LOCK];
  assign o_unlock_key = key_q;

  // Watchdog defaults.
  always_comb begin
    case (word1_q[W1_WIN_SIZE_LO +: 2]) // [RULE_10]
      2'h3: o_watchdog_window_size = WIN_25;
      2'h2: o_watchdog_window_size = WIN_37;
      2'h1: o_watchdog_window_size = WIN_50;
      default: o_watchdog_window_size = WIN_75;
    endcase
  end
  assign o_watchdog_force_on = word1_q[W1_FORCE_ON]; // [RULE_11]
  assign o_watchdog_window_off = word1_q[W1_WIN_OFF]; // [RULE_12]
  // Exponent of two for the postscaler; out-of-range codes clamp.
  assign o_watchdog_postscale = (word1_q[W1_POSTSCALE_LO +: 5] > POSTSCALE_MAX) ?
    POSTSCALE_MAX : word1_q[W1_POSTSCALE_LO +: 5]; // [RULE_13] [RULE_14]

  // The exponent handed to the watchdog never leaves the listed range.
  a_post_clamp: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_14]
    o_watchdog_postscale <= POSTSCALE_MAX)
    else $error("postscale above max");

  // Listed postscale codes pass through untouched.
  a_post_pass: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_13]
    (word1_q[W1_POSTSCALE_LO +: 5] <= POSTSCALE_MAX) |-> o_watchdog_postscale == word1_q[20:16])
    else $error("postscale code altered");

  // Codes above the ceiling act as the ceiling itself.
  a_post_high: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_14]
    (word1_q[W1_POSTSCALE_LO +: 5] > POSTSCALE_MAX) |-> o_watchdog_postscale == POSTSCALE_MAX)
    else $error("postscale not clamped");

  // External programmer access is refused while code protection is on.
  a_prot_block: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_01]
    protect_on |-> !o_ext_prog_allow)
    else $error("external access under protect");

  // Without protection a programmer request goes through.
  a_ext_open: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_01]
    (!protect_on && i_ext_prog_req) |-> o_ext_prog_allow)
    else $error("external access refused");

  // Boot flash self-writes are refused while the boot guard bit is low.
  a_boot_guard: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_02]
    (i_self_write_boot && !word0_q[W0_BOOT_GUARD]) |-> !o_self_write_allow)
    else $error("boot write allowed");

  // With the boot guard bit high, boot flash stays writable.
  a_boot_open: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_02]
    (i_self_write_req && i_self_write_boot && word0_q[W0_BOOT_GUARD]) |-> o_self_write_allow)
    else $error("boot write refused");

  // Guarded page count is the complement of the field, in 1 KB pages.
  a_guard_pages: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_03]
    !word0_q[W0_BOOT_GUARD] |-> o_guard_limit == {~word0_q[19:10], 10'h000})
    else $error("page guard limit wrong");

  // The page guard is void whenever boot flash is left writable.
  a_page_link: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_04]
    word0_q[W0_BOOT_GUARD] |-> o_guard_limit == 20'h00000)
    else $error("page guard without boot guard");

  // A program flash write below the guard limit is never let through.
  a_guard_low: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_04]
    (!i_self_write_boot && i_self_write_addr < o_guard_limit) |-> !o_self_write_allow)
    else $error("guarded page written");

  // The debug channel choice holds once the words are loaded.
  a_chan_hold: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_05]
    (state_q == ST_RUN) |=> $stable(o_debug_channel_select))
    else $error("debug channel moved");

  // Protection forces the debugger off.
  a_debug_off: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_07]
    protect_on |-> !o_debug_enable)
    else $error("debug on under protect");

  // The debugger stays off until the words have been loaded.
  a_debug_load: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_07]
    (state_q == ST_LOAD) |-> !o_debug_enable)
    else $error("debug on before load");

  // Scan enable in the control register starts from word 0.
  a_scan_seed: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_06]
    (state_q == ST_LOAD) |=> o_scan_port_enable == $past(i_nv_word0[W0_SCAN_EN]))
    else $error("scan enable not seeded");

  // Window size code 11 gives a quarter of the timeout.
  a_win_quarter: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_10]
    (word1_q[W1_WIN_SIZE_LO +: 2] == 2'h3) |-> o_watchdog_window_size == WIN_25)
    else $error("window size 11 wrong");

  // Window size code 10 gives three eighths.
  a_win_mid: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_10]
    (word1_q[W1_WIN_SIZE_LO +: 2] == 2'h2) |-> o_watchdog_window_size == WIN_37)
    else $error("window size 10 wrong");

  // Window size code 01 gives half.
  a_win_half: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_10]
    (word1_q[W1_WIN_SIZE_LO +: 2] == 2'h1) |-> o_watchdog_window_size == WIN_50)
    else $error("window size 01 wrong");

  // Window size code 00 gives three quarters.
  a_win_wide: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_10]
    (word1_q[W1_WIN_SIZE_LO +: 2] == 2'h0) |-> o_watchdog_window_size == WIN_75)
    else $error("window size 00 wrong");

  // Software can never drop a forced watchdog while running.
  a_force_hold: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_11]
    (state_q == ST_RUN) |=> $stable(o_watchdog_force_on))
    else $error("force-on changed");

  // Window mode selection holds once loaded.
  a_window_hold: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_12]
    (state_q == ST_RUN) |=> $stable(o_watchdog_window_off))
    else $error("window mode changed");

  // The load step lasts exactly one cycle.
  a_load_once: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_18]
    (state_q == ST_LOAD) |=> (state_q == ST_RUN))
    else $error("load step not single");

  // Loaded words never change until the next reset.
  a_words_hold: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_18]
    (state_q == ST_RUN) |=> $stable(word0_q) && $stable(word1_q))
    else $error("config words changed");

  // The small package never shows a trace enable.
  a_trace_small: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_17]
    SMALL_PACKAGE |-> !o_trace_output_enable)
    else $error("trace on small package");

  // Unimplemented control bits never hold a one.
  a_ctl_zero: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_16]
    (ctl_q & ~ctl_mask) == 32'h00000000)
    else $error("unimplemented control bit set");

  // Unmapped accesses answer with an error and zero data.
  a_unmapped: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_16]
    (i_psel && i_penable && !hit) |-> o_pslverr && (o_prdata == 32'h00000000))
    else $error("unmapped access data");

  // A key read returns the key held at the setup edge.
  a_key_read: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_16]
    (rd_en && i_paddr == OFS_UNLOCK_KEY) |-> o_prdata == key_q)
    else $error("key read wrong");

  // Identity reads return revision above device identifier.
  a_id_read: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_15]
    (i_psel && !i_penable && i_paddr == OFS_PART_IDENTITY) |=> o_prdata == {REVISION, DEVICE_ID})
    else $error("identity read wrong");
endmodule

// *** cfg_decode_pkg.sv ***
// Constants and layouts for the configuration word decoder.
// Overview of operation
// RULE_01 - Code-protect bit low blocks external programmer reads and writes of flash.
// RULE_02 - Boot write guard bit low blocks self-writes to boot flash.
// RULE_03 - Ten-bit page guard is ones complement of protected 1 KB page count.
// RULE_04 - Page guard applies only while boot flash write guard is active.
// RULE_05 - Debug channel select: 11 pair 1, 10 pair 2, 01 pair 3, 00 reserved.
// RULE_06 - Word 0 scan enable bit seeds the control register scan enable at reset.
// RULE_07 - Debugger off when upper field bit is 1; forced to 11 under protection.
// RULE_08 - Programmer writes 0 to word 0 bit 31, 1 to other reserved bits.
// RULE_09 - Programmer writes 1 to word 1 upper six and other reserved bits.
// RULE_10 - Window size code 11 25%, 10 37.5%, 01 50%, 00 75%.
// RULE_11 - Force-on bit 1 runs watchdog unstoppably; 0 leaves it to software.
// RULE_12 - Window-off bit 0 selects window mode, 1 selects non-window mode.
// RULE_13 - Postscaler divides by two to the power of the code, up to 10100.
// RULE_14 - Postscale codes above 10100 behave exactly as 10100.
// RULE_15 - Identity register holds 4-bit revision above 28-bit device identifier.
// RULE_16 - Unimplemented bits of control, identity and key registers read zero.
// RULE_17 - Trace output enable is absent and reads zero on the small package.
// RULE_18 - Configuration fields latch at reset and hold read-only until next reset.
package cfg_decode_pkg;
  // Register byte offsets.
  localparam logic [15:0] OFS_CONFIG_CONTROL = 16'hF200;
  localparam logic [15:0] OFS_PART_IDENTITY = 16'hF220;
  localparam logic [15:0] OFS_UNLOCK_KEY = 16'hF230;
  localparam logic [15:0] OFS_CFG_WORD0 = 16'hF240;
  localparam logic [15:0] OFS_CFG_WORD1 = 16'hF244;
  // Control register fields and reset.
  localparam int CTL_SCAN_DO_EN = 0;
  localparam int CTL_TRACE_EN = 2;
  localparam int CTL_SCAN_EN = 3;
  localparam int CTL_MODULE_LOCK = 12;
  localparam int CTL_PIN_LOCK = 13;
  localparam logic [31:0] CTL_RESET = 32'h0000000B;
  localparam logic [31:0] CTL_IMPL_MASK = 32'h0000300D;
  localparam logic [31:0] KEY_RESET = 32'h00000000;
  // Word 0 fields.
  localparam int W0_CODE_PROTECT = 28;
  localparam int W0_BOOT_GUARD = 24;
  localparam int W0_PAGE_GUARD_LO = 10;
  localparam int W0_CHAN_LO = 3;
  localparam int W0_SCAN_EN = 2;
  localparam int W0_DEBUG_LO = 0;
  // Word 1 fields.
  localparam int W1_WIN_SIZE_LO = 24;
  localparam int W1_FORCE_ON = 23;
  localparam int W1_WIN_OFF = 22;
  localparam int W1_POSTSCALE_LO = 16;
  // Page size shift (0x0400 bytes) and postscale ceiling.
  localparam int PAGE_SHIFT = 10;
  localparam logic [4:0] POSTSCALE_MAX = 5'h14;
  // Debug channel pairs and window sizes in eighths of the timeout.
  typedef enum logic [1:0] {CHAN_NONE = 2'h0, CHAN_PAIR3 = 2'h1, CHAN_PAIR2 = 2'h2,
    CHAN_PAIR1 = 2'h3} debug_chan_t;
  localparam logic [3:0] WIN_25 = 4'h2;
  localparam logic [3:0] WIN_37 = 4'h3;
  localparam logic [3:0] WIN_50 = 4'h4;
  localparam logic [3:0] WIN_75 = 4'h6;
endpackage

// *** nv_programmer.sv ***
// Programmer model that burns the two configuration words.
`timescale 1ns/100ps
module nv_programmer (
  // Field values chosen by the bench.
  input wire logic [31:0] i_f0,
  input wire logic [31:0] i_f1,
  // Words as burned.
  output logic [31:0] o_word0,
  output logic [31:0] o_word1
);
  // Only real fields vary, so a decoder that reads a reserved bit gets the burned level.
  assign o_word0 = (i_f0 & 32'h110FFC1F) | 32'h6EF003E0;
  assign o_word1 = (i_f1 & 32'h03DF0000) | 32'hFC20FFFF;
endmodule

// *** device_config_word_decode_test.sv ***
// Self-checking bench for the configuration word decoder.
`timescale 1ns/100ps
module device_config_word_decode_test;
  import cfg_decode_pkg::*;
  localparam logic [27:0] DID = 28'h0ABCDE1; // Arbitrary value.
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, er = 0, sr = 0, sb = 0, dchk = 0;
  logic pready, pslverr, cp, bg, dben, scan, frc, woff, eal, sal;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h00000000, f0 = 32'h00000000, f1 = 32'h00000000, w0, w1, prdata, r;
  logic [19:0] sa = 20'h00000, lim;
  logic [1:0] chan;
  logic sdo, tro, tro_s, psl, mdl, dctl = 0;
  logic [9:0] pfg;
  logic [31:0] key;
  logic [36:0] exp_cq[$];
  logic [3:0] win;
  logic [4:0] ps;
  logic [32:0] exp_rd[$];
  logic [48:0] exp_dq[$];
  int n_fail = 0, num_checks = 0, cyc = 0;
  nv_programmer prog (.i_f0(f0), .i_f1(f1), .o_word0(w0), .o_word1(w1));
  device_config_word_decode #(.DEVICE_ID(DID), .REVISION(4'h5)) dut (.i_core_clk(clk),
    .i_rst(rst), .i_nv_word0(w0), .i_nv_word1(w1), .i_ext_prog_req(er),
    .i_self_write_req(sr), .i_self_write_addr(sa), .i_self_write_boot(sb),
    .o_ext_prog_allow(eal), .o_self_write_allow(sal), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_code_protect(cp),
    .o_boot_flash_write_guard(bg), .o_program_flash_write_guard(pfg), .o_guard_limit(lim),
    .o_debug_channel_select(chan), .o_debug_enable(dben), .o_scan_port_enable(scan),
    .o_scan_data_out_enable(sdo), .o_trace_output_enable(tro), .o_pin_select_lock(psl),
    .o_module_disable_lock(mdl), .o_watchdog_window_size(win), .o_watchdog_force_on(frc),
    .o_watchdog_window_off(woff), .o_watchdog_postscale(ps), .o_unlock_key(key));
  // Small-package copy on the same inputs, watched only for its trace enable.
  device_config_word_decode #(.DEVICE_ID(DID), .REVISION(4'h5), .SMALL_PACKAGE(1'b1))
    small_dut (.i_core_clk(clk),
    .i_rst(rst), .i_nv_word0(w0), .i_nv_word1(w1), .i_ext_prog_req(er),
    .i_self_write_req(sr), .i_self_write_addr(sa), .i_self_write_boot(sb),
    .o_ext_prog_allow(), .o_self_write_allow(), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(),
    .o_pready(), .o_pslverr(), .o_code_protect(),
    .o_boot_flash_write_guard(), .o_program_flash_write_guard(), .o_guard_limit(),
    .o_debug_channel_select(), .o_debug_enable(), .o_scan_port_enable(),
    .o_scan_data_out_enable(), .o_trace_output_enable(tro_s), .o_pin_select_lock(),
    .o_module_disable_lock(), .o_watchdog_window_size(), .o_watchdog_force_on(),
    .o_watchdog_window_off(), .o_watchdog_postscale(), .o_unlock_key());
  // The 200 MHz core clock.
  initial forever #2.5 clk = ~clk;
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [48:0] e, input logic [48:0] s);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  // Watcher: read data is taken only at the completing edge, as a master would.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (psel && pen && pready === 1'b1 && !pwr) cmp("read", 49'(exp_rd.pop_front()),
      49'({pslverr, prdata}));
    if (dchk) cmp("decode", exp_dq.pop_front(), {pfg, cp, bg, lim, chan, dben, scan, win,
      frc, woff, ps, eal, sal});
    if (dctl) cmp("control", 49'(exp_cq.pop_front()), 49'({sdo, tro, tro_s, psl, mdl, key}));
    if (cyc == 5000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    psel <= 1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) pen <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [32:0] e);
    exp_rd.push_back(e);
    apb(1'b0, a, 32'h00000000);
  endtask
  // Words are only taken at reset, so each new setting needs a fresh reset.
  task automatic load(input logic [31:0] a, input logic [31:0] b);
    rst <= 1;
    f0 <= a;
    f1 <= b;
    repeat (2) @(posedge clk);
    rst <= 0;
    repeat (3) @(posedge clk);
  endtask
  // Control register outputs and key, noted then looked at for one cycle.
  task automatic ctl_chk(input logic [36:0] e);
    exp_cq.push_back(e);
    dctl <= 1;
    @(posedge clk);
    dctl <= 0;
    @(posedge clk);
  endtask
  task automatic check(input logic e, input logic s, input logic b, input logic [19:0] ad);
    logic c, g;
    logic [19:0] l;
    logic [1:0] d, z;
    c = !w0[28];
    g = !w0[24];
    l = g ? {~w0[19:10], 10'h000} : 20'h00000;
    d = c ? 2'h3 : w0[1:0];
    z = w1[25:24];
    exp_dq.push_back({w0[19:10], c, g, l, w0[4:3], !d[1], w0[2],
      z == 2'h3 ? WIN_25 : z == 2'h2 ? WIN_37
      : z == 2'h1 ? WIN_50 : WIN_75, w1[23], w1[22], w1[20:16] > POSTSCALE_MAX ? POSTSCALE_MAX
      : w1[20:16], e & !c, s & (b ? !g : ad >= l)});
    er <= e;
    sr <= s;
    sb <= b;
    sa <= ad;
    dchk <= 1;
    @(posedge clk);
    dchk <= 0;
    @(posedge clk);
  endtask
  initial begin
    r = $urandom(65112);
    repeat (10) @(posedge clk);
    for (int i = 0; i < 12; i++) begin
      r = $urandom;
      r[4:3] = 2'(i % 3 + 1);
      load(r, {6'h00, 2'(i), 1'(i), 1'(i >> 1), 1'b0, 5'(i * 2), 16'h0000});
      check(1'b1, 1'b1, 1'b1, 20'($urandom));
      check(1'b0, 1'b1, 1'b0, {~w0[19:10], 10'h000});
      check(1'b1, 1'b1, 1'b0, {~w0[19:10], 10'h000} - 20'h00001);
    end
    rd(OFS_PART_IDENTITY, {1'b0, 4'h5, DID});
    rd(OFS_UNLOCK_KEY, {1'b0, KEY_RESET});
    apb(1'b1, OFS_CONFIG_CONTROL, 32'hFFFFFFFF);
    rd(OFS_CONFIG_CONTROL, {1'b0, CTL_IMPL_MASK});
    r = $urandom;
    apb(1'b1, OFS_UNLOCK_KEY, r);
    rd(OFS_UNLOCK_KEY, {1'b0, r});
    ctl_chk({5'b11011, r});
    apb(1'b1, OFS_PART_IDENTITY, 32'h00000000);
    rd(OFS_PART_IDENTITY, {1'b0, 4'h5, DID});
    apb(1'b1, OFS_CFG_WORD0, 32'h00000000);
    rd(OFS_CFG_WORD0, {1'b0, w0});
    rd(OFS_CFG_WORD1, {1'b0, w1});
    rd(16'h0004, {1'b1, 32'h00000000});
    stop_test();
  end
endmodule
